// ==== verilog/cpx_pkg.sv ====
// shared constants and types of the operand and alu engine
`default_nettype none
package cpx_pkg;
  localparam logic [7:0]  REG_CTRL  = 8'h00;
  localparam logic [7:0]  REG_STAT  = 8'h04;
  localparam logic [1:0]  REG_GPR   = 2'h1;
  localparam int          CTRL_RUN  = 0;
  localparam int          STAT_BUSY = 0;
  localparam int          STAT_ERR  = 1;
  localparam int          SR_C      = 0;
  localparam int          SR_Z      = 1;
  localparam int          SR_N      = 2;
  localparam int          SR_V      = 8;
  localparam logic [3:0]  PC_IDX    = 4'h0;
  localparam logic [3:0]  SR_IDX    = 4'h2;
  localparam logic [3:0]  CG_IDX    = 4'h3;
  localparam logic [4:0]  EXT_TAG   = 5'h03;
  localparam int          EXT_AL    = 6;
  localparam int          EXT_SRC   = 7;
  localparam int          EXT_DST   = 0;
  localparam logic [19:0] PC_STEP   = 20'h2;
  localparam logic [19:0] INC_B     = 20'h1;
  localparam logic [19:0] INC_W     = 20'h2;
  localparam logic [19:0] INC_A     = 20'h4;
  localparam logic [19:0] MASK_B    = 20'h000ff;
  localparam logic [19:0] MASK_W    = 20'h0ffff;
  localparam logic [19:0] MASK_A    = 20'hfffff;
  localparam logic [19:0] CG_ONE    = 20'h1;
  localparam logic [19:0] CG_TWO    = 20'h2;
  localparam logic [19:0] CG_FOUR   = 20'h4;
  localparam logic [19:0] CG_EIGHT  = 20'h8;
  localparam logic [1:0]  AM_REG    = 2'h0;
  localparam logic [1:0]  AM_IDX    = 2'h1;
  localparam logic [1:0]  AM_IND    = 2'h2;
  localparam logic [1:0]  AM_INC    = 2'h3;
  localparam logic [1:0]  BE_LO     = 2'h1;
  localparam logic [1:0]  BE_HI     = 2'h2;
  localparam logic [1:0]  BE_ALL    = 2'h3;
  typedef enum logic [3:0] {
    copy_op = 4'h4, sum_op = 4'h5, sum_with_carry_op = 4'h6,
    difference_with_borrow_op = 4'h7, difference_op = 4'h8,
    compare_op = 4'h9, decimal_sum_op = 4'ha, mask_test_op = 4'hb,
    mask_clear_op = 4'hc, mask_set_op = 4'hd, xor_op = 4'he,
    and_op = 4'hf
  } cpx_op_e;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_ADDR} cpx_size_e;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_PLAN, ST_RSTB, ST_RWAIT, ST_EXEC, ST_WRITE
  } cpx_state_e;
  typedef enum logic [2:0] {PH_INS, PH_SX, PH_DX, PH_SOP, PH_DOP} cpx_phase_e;
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [1:0]  be;
    logic        rd;
    logic        wr;
  } cpx_mem_s;
  typedef struct packed {
    logic v;
    logic n;
    logic z;
    logic c;
  } cpx_flags_s;
endpackage : cpx_pkg
`default_nettype wire

// ==== verilog/cpx_agen.sv ====
// operand address former and constant generator
`timescale 1ns/10ps
`default_nettype none
module cpx_agen (
  input  wire logic [1:0]  mode,    // addressing mode
  input  wire logic [3:0]  rsel,    // register number
  input  wire logic [19:0] rval,    // register content
  input  wire logic [15:0] word,    // word after the opcode
  input  wire logic [3:0]  msb,     // extension nibble
  input  wire logic        xform,   // extended instruction
  output logic [19:0]      addr,    // operand address
  output logic             cg_hit,  // constant generator used
  output logic [19:0]      cg_val   // generated constant
);
  logic [19:0] sum;

  always_comb begin
    cg_hit = 1'b0;
    cg_val = 20'h0;
    if (rsel == cpx_pkg::CG_IDX) begin
      cg_hit = 1'b1;
      unique case (mode)
        cpx_pkg::AM_REG: cg_val = 20'h0;
        cpx_pkg::AM_IDX: cg_val = cpx_pkg::CG_ONE;
        cpx_pkg::AM_IND: cg_val = cpx_pkg::CG_TWO;
        cpx_pkg::AM_INC: cg_val = cpx_pkg::MASK_A;
      endcase
    end else if (rsel == cpx_pkg::SR_IDX && mode[1]) begin
      cg_hit = 1'b1;
      cg_val = mode[0] ? cpx_pkg::CG_EIGHT : cpx_pkg::CG_FOUR;
    end
    sum  = 20'h0;
    addr = rval;
    if (mode == cpx_pkg::AM_IDX) begin
      if (rsel == cpx_pkg::SR_IDX) begin
        if (xform) addr = {msb, word};
        else addr = {4'h0, word};
      end else if (xform) begin
        addr = rval + {msb, word};
      end else begin
        sum  = rval + {{4{word[15]}}, word};
        addr = (rval[19:16] == 4'h0) ? {4'h0, sum[15:0]} : sum;
      end
    end
  end
endmodule : cpx_agen
`default_nettype wire

// ==== verilog/cpx_alu.sv ====
// double-operand arithmetic and logic unit with status flags
`timescale 1ns/10ps
`default_nettype none
module cpx_alu (
  input  wire cpx_pkg::cpx_op_e   op,     // operation
  input  wire cpx_pkg::cpx_size_e sz,     // operand size
  input  wire logic [19:0]        src,    // source operand
  input  wire logic [19:0]        dst,    // destination operand
  input  wire logic               cin,    // carry flag in
  output logic [19:0]             res,    // result, size masked
  output cpx_pkg::cpx_flags_s     fl,     // new flags
  output logic                    upd,    // flags change
  output logic                    store   // result is written
);
  logic [19:0] m, s, d, a;
  logic [20:0] bin;
  logic        ci, cy, v;
  wire  [5:0]  dc;
  wire  [19:0] bcd;

  function automatic logic top(input logic [19:0] x,
                               input cpx_pkg::cpx_size_e z);
    top = (z == cpx_pkg::SZ_BYTE) ? x[7] :
          (z == cpx_pkg::SZ_WORD) ? x[15] : x[19];
  endfunction : top

  assign dc[0] = cin;
  genvar g;
  for (g = 0; g < 5; g++) begin : g_dig
    wire [4:0] t = {1'b0, d[4*g+:4]} + {1'b0, s[4*g+:4]} + {4'h0, dc[g]};
    wire [4:0] f = t + 5'h06;
    assign dc[g+1] = t > 5'h09;
    assign bcd[4*g+:4] = dc[g+1] ? f[3:0] : t[3:0];
  end

  always_comb begin
    m = (sz == cpx_pkg::SZ_BYTE) ? cpx_pkg::MASK_B :
        (sz == cpx_pkg::SZ_WORD) ? cpx_pkg::MASK_W : cpx_pkg::MASK_A;
    s = src & m;
    d = dst & m;
    a = s;
    ci = 1'b0;
    if (op inside {cpx_pkg::difference_op, cpx_pkg::compare_op}) begin
      a  = ~src & m;
      ci = 1'b1;
    end else if (op == cpx_pkg::difference_with_borrow_op) begin
      a  = ~src & m;
      ci = cin;
    end else if (op == cpx_pkg::sum_with_carry_op) begin
      ci = cin;
    end
    bin = {1'b0, d} + {1'b0, a} + {20'h0, ci};
    res = 20'h0;
    upd = 1'b1;
    store = 1'b1;
    v = 1'b0;
    cy = (sz == cpx_pkg::SZ_BYTE) ? bin[8] :
         (sz == cpx_pkg::SZ_WORD) ? bin[16] : bin[20];
    unique case (op)
      cpx_pkg::copy_op: begin
        res = s;
        upd = 1'b0;
      end
      cpx_pkg::mask_clear_op: begin
        res = ~s & d;
        upd = 1'b0;
      end
      cpx_pkg::mask_set_op: begin
        res = s | d;
        upd = 1'b0;
      end
      cpx_pkg::sum_op, cpx_pkg::sum_with_carry_op,
      cpx_pkg::difference_op, cpx_pkg::difference_with_borrow_op,
      cpx_pkg::compare_op: begin
        res = bin[19:0] & m;
        v = (top(a, sz) == top(d, sz)) && (top(res, sz) != top(d, sz));
        store = op != cpx_pkg::compare_op;
      end
      cpx_pkg::decimal_sum_op: begin
        res = bcd & m;
        cy = (sz == cpx_pkg::SZ_BYTE) ? dc[2] :
             (sz == cpx_pkg::SZ_WORD) ? dc[4] : dc[5];
        v = (top(s, sz) == top(d, sz)) && (top(res, sz) != top(d, sz));
      end
      cpx_pkg::mask_test_op, cpx_pkg::and_op: begin
        res = s & d;
        store = op == cpx_pkg::and_op;
      end
      cpx_pkg::xor_op: begin
        res = s ^ d;
        v = top(s, sz) && top(d, sz);
      end
      default: begin
        upd = 1'b0;
        store = 1'b0;
      end
    endcase
    fl.v = v;
    fl.n = top(res, sz);
    fl.z = res == 20'h0;
    fl.c = (op inside {cpx_pkg::xor_op, cpx_pkg::and_op,
                       cpx_pkg::mask_test_op}) ? !fl.z : cy;
  end
endmodule : cpx_alu
`default_nettype wire

// ==== verilog/cpx_core.sv ====
// operand addressing and double-operand execution engine
`timescale 1ns/10ps
`default_nettype none
module cpx_core (
  input  wire logic         CLK_SYS,    // 40 MHz system clock
  input  wire logic         RESET_N,    // sync reset, active low
  input  wire logic [7:0]   RADDR,      // register byte address
  input  wire logic [31:0]  RWDATA,     // register write data
  input  wire logic         RWR,        // register write strobe
  input  wire logic         RRD,        // register read strobe
  output logic [31:0]       RRDATA,     // read data, next cycle
  output var cpx_pkg::cpx_mem_s MEM_REQ, // memory request
  input  wire logic [15:0]  MEM_RDATA   // memory data, next cycle
);
  typedef struct packed {
    cpx_pkg::cpx_state_e st;
    cpx_pkg::cpx_phase_e ph;
    logic                run;
    logic                err;
    logic                hi;
    logic                xflag;
    logic                gsx;
    logic                gdx;
    logic                gs;
    logic                gd;
    logic [15:0]         ir;
    logic [15:0]         ext;
    logic [15:0]         sx;
    logic [15:0]         dx;
    logic [19:0]         sv;
    logic [19:0]         dv;
    logic [19:0]         wv;
    logic [15:0][19:0]   regs;
    cpx_pkg::cpx_mem_s   mreq;
    logic [31:0]         rdata;
  } cpx_core_s;
  cpx_core_s           s_r;
  cpx_core_s           s_nxt;
  cpx_pkg::cpx_op_e    op;
  cpx_pkg::cpx_size_e  sz;
  cpx_pkg::cpx_flags_s fl;
  logic [3:0]          sreg, dreg, src_msb;
  logic [1:0]          as;
  logic                ad, al, s_imm, s_abs, s_word_need, s_mem;
  logic                sx_go, dx_go, sop_go, dop_go, sop_done;
  logic                cg_hit, alu_upd, alu_store, busy, gpr_hit;
  logic [19:0]         pc, sreg_val, dreg_val, s_addr, d_addr;
  logic [19:0]         cg_val, imm, src_op, dst_op, res, inc_amt;
  logic [15:0]         rdword;
  logic [3:0]          flags;
  assign op       = cpx_pkg::cpx_op_e'(s_r.ir[15:12]);
  assign sreg     = s_r.ir[11:8];
  assign ad       = s_r.ir[7];
  assign as       = s_r.ir[5:4];
  assign dreg     = s_r.ir[3:0];
  assign src_msb  = s_r.ext[cpx_pkg::EXT_SRC+:4];
  assign al       = s_r.xflag ? s_r.ext[cpx_pkg::EXT_AL] : 1'b1;
  assign sz       = !al ? cpx_pkg::SZ_ADDR :
                    s_r.ir[6] ? cpx_pkg::SZ_BYTE : cpx_pkg::SZ_WORD;
  assign pc       = s_r.regs[cpx_pkg::PC_IDX];
  assign sreg_val = s_r.regs[sreg];
  assign dreg_val = s_r.regs[dreg];
  assign flags    = {s_r.regs[cpx_pkg::SR_IDX][cpx_pkg::SR_V],
                     s_r.regs[cpx_pkg::SR_IDX][cpx_pkg::SR_N:0]};
  assign busy     = s_r.st != cpx_pkg::ST_IDLE;
  assign gpr_hit  = RADDR[7:6] == cpx_pkg::REG_GPR && RADDR[1:0] == 2'h0;
  assign inc_amt  = (sz == cpx_pkg::SZ_BYTE) ? cpx_pkg::INC_B :
                    (sz == cpx_pkg::SZ_WORD) ? cpx_pkg::INC_W :
                    cpx_pkg::INC_A;
  // source mode decode
  assign s_imm = as == cpx_pkg::AM_INC && sreg == cpx_pkg::PC_IDX;
  assign s_abs = as == cpx_pkg::AM_IDX && sreg == cpx_pkg::SR_IDX;
  assign s_word_need = !cg_hit && (as == cpx_pkg::AM_IDX || s_imm);
  assign s_mem = !cg_hit && as != cpx_pkg::AM_REG && !s_imm;
  assign imm = s_r.xflag ? {src_msb, s_r.sx}
                         : {4'h0, s_r.sx};
  assign src_op = s_mem ? s_r.sv : s_imm ? imm :
                  cg_hit ? cg_val : sreg_val;
  assign dst_op = ad ? s_r.dv : dreg_val;
  // read planning in priority order
  assign sx_go  = s_r.st == cpx_pkg::ST_PLAN && s_word_need && !s_r.gsx;
  assign dx_go  = s_r.st == cpx_pkg::ST_PLAN && !sx_go && ad
                  && !s_r.gdx;
  assign sop_go = s_r.st == cpx_pkg::ST_PLAN && !sx_go && !dx_go
                  && s_mem && !s_r.gs;
  assign dop_go = s_r.st == cpx_pkg::ST_PLAN && !sx_go && !dx_go
                  && !sop_go && ad && op != cpx_pkg::copy_op && !s_r.gd;
  assign sop_done = s_r.st == cpx_pkg::ST_RWAIT && s_r.ph == cpx_pkg::PH_SOP
                    && (sz != cpx_pkg::SZ_ADDR || s_r.hi);
  assign rdword = (sz == cpx_pkg::SZ_BYTE && s_r.mreq.addr[0])
                  ? {8'h00, MEM_RDATA[15:8]} : MEM_RDATA;
  cpx_agen u_src_agen (
    .mode   (as),
    .rsel   (sreg),
    .rval   (sreg_val),
    .word   (s_r.sx),
    .msb    (src_msb),
    .xform  (s_r.xflag),
    .addr   (s_addr),
    .cg_hit (cg_hit),
    .cg_val (cg_val)
  );
  // destination is always indexed mode, off the current register value except for SR_IDX, which gives an absolute address
  cpx_agen u_dst_agen (
    .mode   (cpx_pkg::AM_IDX),
    .rsel   (dreg),
    .rval   (dreg_val),
    .word   (s_r.dx),
    .msb    (s_r.ext[cpx_pkg::EXT_DST+:4]),
    .xform  (s_r.xflag),
    .addr   (d_addr),
    .cg_hit (),
    .cg_val ()
  );
  cpx_alu u_alu (
    .op    (op),
    .sz    (sz),
    .src   (src_op),
    .dst   (dst_op),
    .cin   (s_r.regs[cpx_pkg::SR_IDX][cpx_pkg::SR_C]),
    .res   (res),
    .fl    (fl),
    .upd   (alu_upd),
    .store (alu_store)
  );
  always_comb begin
    logic [19:0]         ia;
    cpx_pkg::cpx_phase_e ip;
    logic                go;
    ia = 20'h0;
    ip = cpx_pkg::PH_INS;
    go = 1'b0;
    s_nxt = s_r;
    s_nxt.mreq.rd = 1'b0;
    s_nxt.mreq.wr = 1'b0;
    s_nxt.rdata = 32'h0;
    if (RRD) begin
      if (RADDR == cpx_pkg::REG_CTRL) s_nxt.rdata = {31'h0, s_r.run};
      else if (RADDR == cpx_pkg::REG_STAT)
        s_nxt.rdata = {30'h0, s_r.err, busy};
      else if (gpr_hit) s_nxt.rdata = {12'h0, s_r.regs[RADDR[5:2]]};
    end
    if (RWR) begin
      if (RADDR == cpx_pkg::REG_CTRL) s_nxt.run = RWDATA[cpx_pkg::CTRL_RUN];
      else if (RADDR == cpx_pkg::REG_STAT && RWDATA[cpx_pkg::STAT_ERR])
        s_nxt.err = 1'b0;
      else if (gpr_hit && !busy) s_nxt.regs[RADDR[5:2]] = RWDATA[19:0];
    end
    unique case (s_r.st)
      cpx_pkg::ST_IDLE: begin
        if (s_r.run) s_nxt.st = cpx_pkg::ST_FETCH;
      end
      cpx_pkg::ST_FETCH: begin
        s_nxt.gsx = 1'b0;
        s_nxt.gdx = 1'b0;
        s_nxt.gs = 1'b0;
        s_nxt.gd = 1'b0;
        if (!s_r.run) begin
          s_nxt.st = cpx_pkg::ST_IDLE;
          s_nxt.xflag = 1'b0;
        end else begin
          go = 1'b1;
          ia = pc;
          ip = cpx_pkg::PH_INS;
        end
      end
      cpx_pkg::ST_PLAN: begin
        go = 1'b1;
        if (sx_go) begin
          ia = pc;
          ip = cpx_pkg::PH_SX;
        end else if (dx_go) begin
          ia = pc;
          ip = cpx_pkg::PH_DX;
        end else if (sop_go) begin
          ia = s_addr;
          ip = cpx_pkg::PH_SOP;
        end else if (dop_go) begin
          ia = d_addr;
          ip = cpx_pkg::PH_DOP;
        end else begin
          go = 1'b0;
          s_nxt.st = cpx_pkg::ST_EXEC;
        end
      end
      cpx_pkg::ST_RSTB: begin
        s_nxt.st = cpx_pkg::ST_RWAIT;
      end
      cpx_pkg::ST_RWAIT: begin
        s_nxt.st = cpx_pkg::ST_PLAN;
        unique case (s_r.ph)
          cpx_pkg::PH_INS: begin
            s_nxt.regs[cpx_pkg::PC_IDX] = pc + cpx_pkg::PC_STEP;
            if (!s_r.xflag && MEM_RDATA[15:11] == cpx_pkg::EXT_TAG) begin
              s_nxt.ext = MEM_RDATA;
              s_nxt.xflag = 1'b1;
              s_nxt.st = cpx_pkg::ST_FETCH;
            end else if (MEM_RDATA[15:14] == 2'h0) begin
              s_nxt.err = 1'b1;
              s_nxt.run = 1'b0;
              s_nxt.xflag = 1'b0;
              s_nxt.st = cpx_pkg::ST_IDLE;
            end else begin
              s_nxt.ir = MEM_RDATA;
            end
          end
          cpx_pkg::PH_SX: begin
            s_nxt.sx = MEM_RDATA;
            s_nxt.gsx = 1'b1;
            s_nxt.regs[cpx_pkg::PC_IDX] = pc + cpx_pkg::PC_STEP;
          end
          cpx_pkg::PH_DX: begin
            s_nxt.dx = MEM_RDATA;
            s_nxt.gdx = 1'b1;
            s_nxt.regs[cpx_pkg::PC_IDX] = pc + cpx_pkg::PC_STEP;
          end
          cpx_pkg::PH_SOP, cpx_pkg::PH_DOP: begin
            if (s_r.hi) ia = {MEM_RDATA[3:0], s_r.ph == cpx_pkg::PH_SOP
                              ? s_r.sv[15:0] : s_r.dv[15:0]};
            else ia = {4'h0, rdword};
            if (s_r.ph == cpx_pkg::PH_SOP) s_nxt.sv = ia;
            else s_nxt.dv = ia;
            ia = 20'h0;
            if (sz == cpx_pkg::SZ_ADDR && !s_r.hi) begin
              s_nxt.hi = 1'b1;
              go = 1'b1;
              ia = s_r.mreq.addr + cpx_pkg::PC_STEP;
              ip = s_r.ph;
            end else begin
              s_nxt.hi = 1'b0;
              if (s_r.ph == cpx_pkg::PH_DOP) s_nxt.gd = 1'b1;
              else s_nxt.gs = 1'b1;
              if (sop_done && as == cpx_pkg::AM_INC)
                s_nxt.regs[sreg] = sreg_val + inc_amt;
            end
          end
          default: s_nxt.st = cpx_pkg::ST_IDLE;
        endcase
      end
      cpx_pkg::ST_EXEC: begin
        s_nxt.wv = res;
        s_nxt.st = cpx_pkg::ST_FETCH;
        s_nxt.xflag = 1'b0;
        if (alu_upd) begin
          s_nxt.regs[cpx_pkg::SR_IDX][cpx_pkg::SR_V] = fl.v;
          s_nxt.regs[cpx_pkg::SR_IDX][cpx_pkg::SR_N] = fl.n;
          s_nxt.regs[cpx_pkg::SR_IDX][cpx_pkg::SR_Z] = fl.z;
          s_nxt.regs[cpx_pkg::SR_IDX][cpx_pkg::SR_C] = fl.c;
        end
        if (alu_store && !ad && dreg != cpx_pkg::CG_IDX) begin
          s_nxt.regs[dreg] = res;
        end else if (alu_store && ad) begin
          s_nxt.st = cpx_pkg::ST_WRITE;
          s_nxt.xflag = s_r.xflag;
          s_nxt.mreq.wr = 1'b1;
          s_nxt.mreq.addr = d_addr;
          s_nxt.mreq.wdata = res[15:0];
          s_nxt.mreq.be = cpx_pkg::BE_ALL;
          if (sz == cpx_pkg::SZ_BYTE) begin
            s_nxt.mreq.wdata = {res[7:0], res[7:0]};
            s_nxt.mreq.be = d_addr[0] ? cpx_pkg::BE_HI : cpx_pkg::BE_LO;
          end
        end
      end
      cpx_pkg::ST_WRITE: begin
        if (sz == cpx_pkg::SZ_ADDR && !s_r.hi) begin
          s_nxt.hi = 1'b1;
          s_nxt.mreq.wr = 1'b1;
          s_nxt.mreq.addr = s_r.mreq.addr + cpx_pkg::PC_STEP;
          s_nxt.mreq.wdata = {12'h0, s_r.wv[19:16]};
          s_nxt.mreq.be = cpx_pkg::BE_ALL;
        end else begin
          s_nxt.hi = 1'b0;
          s_nxt.xflag = 1'b0;
          s_nxt.st = cpx_pkg::ST_FETCH;
        end
      end
      default: s_nxt.st = cpx_pkg::ST_IDLE;
    endcase
    if (go) begin
      s_nxt.mreq.rd = 1'b1;
      s_nxt.mreq.addr = ia;
      s_nxt.ph = ip;
      s_nxt.st = cpx_pkg::ST_RSTB;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) s_r <= '0;
    else s_r <= s_nxt;
  end
  assign RRDATA = s_r.rdata;
  assign MEM_REQ = s_r.mreq;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  a_abs_base_addr: assert property (
    sop_go && s_abs && !s_r.xflag
    |=> MEM_REQ.rd && MEM_REQ.addr == {4'h0, $past(s_r.sx)})
    else $error("base absolute source address wrong");
  a_abs_ext_addr: assert property (
    sop_go && s_abs && s_r.xflag
    |=> MEM_REQ.addr == {$past(src_msb), $past(s_r.sx)})
    else $error("extended absolute source address wrong");
  a_ind_keep_reg: assert property (
    sop_go && as == cpx_pkg::AM_IND && sz != cpx_pkg::SZ_ADDR
    |=> (MEM_REQ.addr == $past(sreg_val))
        ##2 (sreg_val == $past(sreg_val, 3)))
    else $error("indirect address or register wrong");
  a_autoinc_step: assert property (
    sop_done && as == cpx_pkg::AM_INC
    |=> sreg_val == $past(sreg_val) + $past(inc_amt))
    else $error("autoincrement step wrong");
  a_pc_step: assert property (
    s_r.st == cpx_pkg::ST_RWAIT && s_r.ph == cpx_pkg::PH_SX
    |=> pc == $past(pc) + cpx_pkg::PC_STEP)
    else $error("pc not advanced after extra word");
  a_word_fetch: assert property (
    sx_go |=> MEM_REQ.rd && MEM_REQ.addr == $past(pc) ##1 !MEM_REQ.rd)
    else $error("extra source word not fetched at pc");
  a_cg_no_word: assert property (
    s_r.st == cpx_pkg::ST_EXEC && cg_hit |-> !s_r.gsx)
    else $error("extra word fetched for generated constant");
  a_logic_keep: assert property (
    s_r.st == cpx_pkg::ST_EXEC && op inside {cpx_pkg::copy_op,
      cpx_pkg::mask_clear_op, cpx_pkg::mask_set_op}
    && !(!ad && dreg == cpx_pkg::SR_IDX) |=> flags == $past(flags))
    else $error("flags changed by copy or mask op");
  a_carry_not_z: assert property (
    s_r.st == cpx_pkg::ST_EXEC && op inside {cpx_pkg::xor_op,
      cpx_pkg::and_op, cpx_pkg::mask_test_op}
    && !(!ad && dreg == cpx_pkg::SR_IDX)
    |=> flags[0] != flags[1])
    else $error("derived carry does not invert zero");
  a_cmp_no_store: assert property (
    s_r.st == cpx_pkg::ST_EXEC && op == cpx_pkg::compare_op
    |=> !MEM_REQ.wr && s_r.st == cpx_pkg::ST_FETCH)
    else $error("compare result was stored");
  c_imm_exec: cover property (s_r.st == cpx_pkg::ST_EXEC && s_imm);
  c_ext_exec: cover property (s_r.st == cpx_pkg::ST_EXEC && s_r.xflag);
  c_autoinc: cover property (sop_done && as == cpx_pkg::AM_INC);
  c_dec_sum: cover property (s_r.st == cpx_pkg::ST_EXEC
                             && op == cpx_pkg::decimal_sum_op);
endmodule : cpx_core
`default_nettype wire

// ==== bench/cpx_mem_model.sv ====
// program and data memory seen over the memory bus
`timescale 1ns/10ps
`default_nettype none
module cpx_mem_model (
  input  wire logic              clk,   // system clock
  input  wire cpx_pkg::cpx_mem_s req,   // request from the engine
  output logic [15:0]            rdata  // read data, next cycle
);
  logic [15:0] mem [0:32767];
  always @(posedge clk) begin
    // data only after a read strobe, else a changing pattern
    if (req.rd) rdata <= mem[req.addr[15:1]];
    else rdata <= ~rdata;
    if (req.wr && req.be[0]) mem[req.addr[15:1]][7:0] <= req.wdata[7:0];
    if (req.wr && req.be[1]) mem[req.addr[15:1]][15:8] <= req.wdata[15:8];
  end
endmodule : cpx_mem_model
`default_nettype wire

// ==== bench/cpx_core_tb.sv ====
// self-checking bench of the operand and alu engine
`timescale 1ns/10ps
`default_nettype none
module cpx_core_tb;
  logic              clk_sys = 1'b0;
  logic              reset_n = 1'b0;
  logic [7:0]        raddr = 8'h00;
  logic [31:0]       rwdata = 32'h0;
  logic [31:0]       rrdata;
  logic [31:0]       v;
  logic              rwr = 1'b0;
  logic              rrd = 1'b0;
  cpx_pkg::cpx_mem_s mem_req;
  logic [15:0]       mem_rdata;
  int                err_count = 0;
  int                n_compared = 0;
  always #12.5 clk_sys = ~clk_sys;
  cpx_core cpx_core_i (.CLK_SYS(clk_sys), .RESET_N(reset_n),
    .RADDR(raddr), .RWDATA(rwdata), .RWR(rwr), .RRD(rrd),
    .RRDATA(rrdata), .MEM_REQ(mem_req), .MEM_RDATA(mem_rdata));
  cpx_mem_model cpx_mem_model_i (.clk(clk_sys), .req(mem_req),
    .rdata(mem_rdata));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    raddr <= a;
    rwdata <= d;
    rwr <= 1'b1;
    @(posedge clk_sys);
    rwr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    raddr <= a;
    rrd <= 1'b1;
    @(posedge clk_sys);
    rrd <= 1'b0;
    #1 d = rrdata;
  endtask : rd
  task automatic chk(input logic [31:0] g, e, input string m);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic test_regs;
    rd(8'h00, v);
    chk(v, 32'h0, "ctrl reset");
    wr(8'h20, 32'hffff);
    rd(8'h20, v);
    chk(v, 32'h0, "unmapped read");
    $display("test_regs done");
  endtask : test_regs
  task automatic test_prog;
    // add @r5+,r6 ; xor #1235,r6 ; copy.b r5,&0200 ; halt
    cpx_mem_model_i.mem[16'h800] = 16'h5536;
    cpx_mem_model_i.mem[16'h801] = 16'he036;
    cpx_mem_model_i.mem[16'h802] = 16'h1235;
    cpx_mem_model_i.mem[16'h803] = 16'h45c2;
    cpx_mem_model_i.mem[16'h804] = 16'h0200;
    cpx_mem_model_i.mem[16'h805] = 16'h0000;
    cpx_mem_model_i.mem[16'h080] = 16'h1234;
    cpx_mem_model_i.mem[16'h100] = 16'hffff;
    wr(8'h54, 32'h100);
    wr(8'h58, 32'h1);
    wr(8'h48, 32'h1);
    wr(8'h40, 32'h1000);
    wr(8'h00, 32'h1);
    v = 32'h0;
    for (int i = 0; i < 100 && v[1] !== 1'b1; i++) rd(8'h04, v);
    chk(v, 32'h2, "first halt flagged");
    rd(8'h58, v);
    chk(v, 32'h0, "xor result");
    rd(8'h54, v);
    chk(v, 32'h102, "autoincrement");
    rd(8'h48, v);
    chk(v, 32'h2, "flags after xor");
    chk(cpx_mem_model_i.mem[16'h100], 32'hff02, "byte store");
    rd(8'h00, v);
    chk(v, 32'h0, "run cleared");
    $display("test_prog done");
  endtask : test_prog
  task automatic test_ext;
    // ext copy.a &10300,r7 ; decimal r8,r9 ; compare r9,r10
    // mask_clear #1,r10 ; halt
    cpx_mem_model_i.mem[16'h880] = 16'h1880;
    cpx_mem_model_i.mem[16'h881] = 16'h4217;
    cpx_mem_model_i.mem[16'h882] = 16'h0300;
    cpx_mem_model_i.mem[16'h883] = 16'ha809;
    cpx_mem_model_i.mem[16'h884] = 16'h990a;
    cpx_mem_model_i.mem[16'h885] = 16'hc31a;
    cpx_mem_model_i.mem[16'h886] = 16'h0000;
    cpx_mem_model_i.mem[16'h180] = 16'h5678;
    cpx_mem_model_i.mem[16'h181] = 16'h0009;
    wr(8'h04, 32'h2);
    wr(8'h48, 32'h1);
    wr(8'h60, 32'h199);
    wr(8'h64, 32'h1);
    wr(8'h68, 32'h201);
    wr(8'h40, 32'h1100);
    wr(8'h00, 32'h1);
    v = 32'h0;
    for (int i = 0; i < 100 && v[1] !== 1'b1; i++) rd(8'h04, v);
    chk(v, 32'h2, "second halt flagged");
    rd(8'h5c, v);
    chk(v, 32'h95678, "extended absolute word");
    rd(8'h64, v);
    chk(v, 32'h201, "decimal sum");
    rd(8'h68, v);
    chk(v, 32'h200, "mask clear by constant");
    rd(8'h48, v);
    chk(v, 32'h3, "flags after compare");
    rd(8'h40, v);
    chk(v, 32'h110e, "words consumed");
    $display("test_ext done");
  endtask : test_ext
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    test_regs();
    test_prog();
    test_ext();
    test_done();
  end
  initial begin
    #(25 * 20000);
    err_count++;
    test_done();
  end
endmodule : cpx_core_tb
`default_nettype wire
